// ---- src/ebf_params.svh ----
// Formatter offsets, fields, resets
`ifndef EBF_PARAMS_SVH
`define EBF_PARAMS_SVH
// Register offsets (byte addresses)
`define EBF_OFS_BUF_HI   16'h07FC
`define EBF_OFS_CBLT_HI  16'h07FF
`define EBF_OFS_FWREV    16'h1000
`define EBF_OFS_SLOT     16'h1002
`define EBF_OFS_MCST_LO  16'h1006
`define EBF_OFS_MCST_HI  16'h10BF
`define EBF_OFS_SET2     16'h1032
`define EBF_OFS_CLR2     16'h1034
`define EBF_OFS_CRATE    16'h103C
`define EBF_OFS_ROM_LO   16'h8000
// Word field positions
`define EBF_GEO_LSB      27
`define EBF_TYPE_LSB     24
`define EBF_CRATE_LSB    16
`define EBF_CNT_LSB      8
`define EBF_CH_LSB       16
`define EBF_BELOW_BIT    13
`define EBF_OVF_BIT      12
`define EBF_KEEPB_BIT_A  3
`define EBF_KEEPB_BIT_B  4
// Reset values
`define EBF_SLOT_RST     5'h1F
`define EBF_CRATE_RST    8'h00
`define EBF_SET2_RST     16'h0000
// Slot capture cycle after reset
`define EBF_SLOT_LOAD_AT 2'h2
`endif

// ---- src/ebf_pkg.sv ----
// Formatter types
package ebf_pkg;
   // Word type codes in bits 26..24
   typedef enum logic [2:0] {
      WT_DATA = 3'h0,
      WT_HDR  = 3'h2,
      WT_END  = 3'h4,
      WT_NV   = 3'h6
   } ebf_word_type_t;
   // Formatter sequence states
   typedef enum logic [1:0] {
      S_IDLE, S_HEAD, S_DATA, S_END
   } ebf_fmt_state_t;
   // Bus access modes
   typedef enum logic [1:0] {
      AM_SINGLE, AM_CBLT, AM_MCST
   } ebf_acc_mode_t;
endpackage : ebf_pkg

// ---- src/ebf_formatter.sv ----
// Event record formatter, staging FIFO and readout buffer
`include "ebf_params.svh"

// Staging FIFO
module ebf_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input  wire logic             i_core_clk,  // Clock
   input  wire logic             i_reset,     // Async reset
   input  wire logic             i_flush,     // Sync empty
   input  wire logic             i_in_valid,  // Write request
   output logic                  o_in_ready,  // Not full
   input  wire logic [WIDTH-1:0] i_in_data,   // Write data
   output logic                  o_out_valid, // Not empty
   input  wire logic             i_out_ready, // Read request
   output logic      [WIDTH-1:0] o_out_data   // Head word
);
   localparam int AW = $clog2(DEPTH);
   // Depth must be a power of two
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("ebf_fifo: DEPTH not a power of two");
   end
   logic [WIDTH-1:0] mem_ff [DEPTH];     // Storage
   logic [AW:0]      wr_ff;              // Write pointer
   logic [AW:0]      rd_ff;              // Read pointer
   wire              full;
   wire              push;
   wire              pop;
   assign full = (wr_ff[AW] != rd_ff[AW]) &&
                 (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
   assign o_in_ready  = ~full;
   assign o_out_valid = (wr_ff != rd_ff);
   assign o_out_data  = mem_ff[rd_ff[AW-1:0]];
   assign push = i_in_valid & ~full;
   assign pop  = i_out_ready & o_out_valid;
   // Storage write
   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem_ff[wr_ff[AW-1:0]] <= i_in_data;
      end
   end
   // Pointers
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else if (i_flush) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         wr_ff <= wr_ff + (AW+1)'(push);
         rd_ff <= rd_ff + (AW+1)'(pop);
      end
   end
endmodule : ebf_fifo

// Functional notes
// [RULE1] Read-only buffer window to 0x07FC
// [RULE2] Header, data words, end word
// [RULE3] Bits 31-27 slot code
// [RULE4] Bits 26-24 word type
// [RULE5] Header crate number
// [RULE6] Header data word count
// [RULE7] Channel in bits 20-16 or 20-17
// [RULE8] Bit 13 below threshold
// [RULE9] Set2 bits 3,4 keep low words
// [RULE10] Bit 12 overflow
// [RULE11] Bits 11-0 value
// [RULE12] End word event counter
// [RULE13] Empty read gives not-valid word
// [RULE14] Halves stored interleaved
// [RULE15] Rejected channels omitted, order kept
// [RULE16] No qualifying channel, no event
// [RULE17] Chained mode: buffer window only
// [RULE18] Multicast: control writes only
// [RULE19] Slot writes only without slot source
// [RULE20] Master sets slot before chained
// [RULE21] Revision word at 0x1000
// [RULE22] ROM space 0x8000-0xFFFF
// [RULE23] Slot reloaded on reset
// [RULE24] Flag shows stored event
// [RULE25] Reads in stored order
module ebf_formatter_top
   import ebf_pkg::*;
#(
   parameter int          NCH       = 32,
   parameter int          MEM_DEPTH = 512,
   parameter int          FIFO_DEP  = 32,
   parameter logic [15:0] FW_REV    = 16'h0A5C  // Arbitrary value
) (
   input  wire logic              i_core_clk,     // 125 MHz clock
   input  wire logic              i_reset,        // Hardware reset
   input  wire logic              i_data_reset,   // Data reset pulse
   input  wire logic              i_soft_reset,   // Software reset pulse
   input  wire logic [4:0]        i_slot_pins,    // Backplane slot code
   input  wire logic              i_aux_present,  // Aux slot connector
   input  wire logic              i_gate_done,    // Samples ready pulse
   input  wire logic [NCH*12-1:0] i_samp_value,   // Converted values
   input  wire logic [NCH-1:0]    i_samp_ovf,     // Overflow per channel
   input  wire logic [NCH-1:0]    i_samp_below,   // Below threshold
   input  wire logic [NCH-1:0]    i_chan_kill,    // Channel disabled
   input  wire logic              i_zero_supp_en, // Drop below-threshold
   input  wire logic              i_ovf_supp_en,  // Drop overflow
   input  wire logic [23:0]       i_event_count,  // Event counter
   output logic                   o_gate_ready,   // Formatter idle
   input  wire logic              i_acc_req,      // Access strobe
   input  wire logic              i_acc_write,    // 1 write, 0 read
   input  wire logic              i_acc_wide,     // 64-bit read
   input  wire logic [1:0]        i_acc_mode,     // Access mode
   input  wire logic [15:0]       i_acc_addr,     // Byte offset
   input  wire logic [15:0]       i_acc_wdata,    // Write data
   output logic                   o_acc_ack,      // Access done
   output logic                   o_acc_nack,     // No response
   output logic [63:0]            o_acc_rdata,    // Read data
   output logic                   o_events_present, // Event stored
   output logic                   o_no_slot_source  // No slot pins
);
   localparam int MAW  = $clog2(MEM_DEPTH);
   localparam int MW   = MAW + 1;
   localparam int HALF = NCH / 2;
   // Only 32 or 16 channels served
   if ((NCH != 32 && NCH != 16) ||
       (1 << MAW) != MEM_DEPTH || MEM_DEPTH < 64) begin : g_chk
      $error("ebf_formatter_top: bad NCH or MEM_DEPTH");
   end

   // Pin synchronisers
   logic [4:0]  slot_s1_ff;         // First stage
   logic [4:0]  slot_s2_ff;         // Second stage
   logic        aux_s1_ff;          // First stage
   logic        aux_s2_ff;          // Second stage
   // Registers
   logic [4:0]  slot_ff;            // Slot position code
   logic [1:0]  load_cnt_ff;        // Capture delay
   logic [7:0]  crate_ff;           // Crate number
   logic [15:0] set2_ff;            // Second flag set
   // Formatter
   ebf_fmt_state_t st_ff;           // Sequence state
   ebf_fmt_state_t nxt_st;
   logic [4:0]  step_ff;            // Slot in storage order
   logic [NCH*12-1:0] val_ff;       // Latched values
   logic [NCH-1:0] ovf_ff;          // Latched overflow
   logic [NCH-1:0] below_ff;        // Latched below flags
   logic [NCH-1:0] mask_ff;         // Channels to store
   logic [5:0]  cnt_ff;             // Data words in event
   logic [23:0] evc_ff;             // Latched counter
   logic [7:0]  crate_lat_ff;       // Latched crate number
   logic        gate_rdy_ff;        // Idle output
   // Event memory
   logic [31:0] ev_mem_ff [MEM_DEPTH]; // Event words
   logic [MAW-1:0] wr_ptr_ff;       // Write pointer
   logic [MAW-1:0] rd_ptr_ff;       // Read pointer
   logic [MAW:0]   words_ff;        // Words held
   logic [MAW:0]   events_ff;       // Complete events held
   // Bus answer
   logic        ack_ff;             // Ack pulse
   logic        nack_ff;            // No-response pulse
   logic [63:0] rdata_ff;           // Read data
   logic        evp_ff;             // Events present

   // Channel qualification
   wire         keep_below;
   wire [NCH-1:0] qual;
   assign keep_below = set2_ff[`EBF_KEEPB_BIT_A] &
                       set2_ff[`EBF_KEEPB_BIT_B];  // [RULE9]
   for (genvar g = 0; g < NCH; g++) begin : g_qual
      assign qual[g] = ~i_chan_kill[g] &
                       ~(i_samp_ovf[g] & i_ovf_supp_en) &
                       ~(i_samp_below[g] & i_zero_supp_en &
                         ~keep_below);  // [RULE15]
   end

   // Number of set bits
   function automatic logic [5:0] popcnt(input logic [NCH-1:0] m);
      logic [5:0] c;
      c = '0;
      for (int i = 0; i < NCH; i++) begin
         c = c + 6'(m[i]);
      end
      return c;
   endfunction : popcnt

   wire [5:0]  qual_cnt;
   wire [4:0]  cur_ch;
   wire [4:0]  ch_field;
   wire [11:0] cur_val;
   wire        last_step;
   wire        f_in_ready;
   wire        f_in_valid;
   logic [31:0] fmt_word;
   assign qual_cnt = popcnt(qual);
   // Interleave halves
   assign cur_ch = step_ff[0] ? ({1'b0, step_ff[4:1]} + 5'(HALF))
                              : {1'b0, step_ff[4:1]};  // [RULE14]
   assign ch_field = (NCH == 32) ? cur_ch
                                 : {cur_ch[3:0], 1'b0};  // [RULE7]
   assign cur_val   = val_ff[cur_ch*12 +: 12];
   assign last_step = (step_ff == 5'(NCH - 1));
   assign f_in_valid = (st_ff == S_HEAD) || (st_ff == S_END) ||
                       ((st_ff == S_DATA) && mask_ff[cur_ch]);

   // Record word assembly
   always_comb begin
      fmt_word = '0;
      fmt_word[`EBF_GEO_LSB +: 5] = slot_ff;  // [RULE3]
      case (st_ff)
         S_HEAD: begin
            fmt_word[`EBF_TYPE_LSB +: 3] = WT_HDR;  // [RULE4]
            fmt_word[`EBF_CRATE_LSB +: 8] = crate_lat_ff;  // [RULE5]
            fmt_word[`EBF_CNT_LSB +: 6] = cnt_ff;  // [RULE6]
         end
         S_DATA: begin
            fmt_word[`EBF_TYPE_LSB +: 3] = WT_DATA;  // [RULE4]
            fmt_word[`EBF_CH_LSB +: 5] = ch_field;  // [RULE7]
            fmt_word[`EBF_BELOW_BIT] = below_ff[cur_ch];  // [RULE8]
            fmt_word[`EBF_OVF_BIT] = ovf_ff[cur_ch];  // [RULE10]
            fmt_word[11:0] = cur_val;  // [RULE11]
         end
         S_END: begin
            fmt_word[`EBF_TYPE_LSB +: 3] = WT_END;  // [RULE4]
            fmt_word[23:0] = evc_ff;  // [RULE12]
         end
         default: begin
            fmt_word = '0;
         end
      endcase
   end

   // Word sequence
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         S_IDLE: begin
            if (i_gate_done && qual_cnt != 6'h00) begin
               nxt_st = S_HEAD;  // [RULE16]
            end
         end
         S_HEAD: begin
            if (f_in_ready) begin
               nxt_st = S_DATA;  // [RULE2]
            end
         end
         S_DATA: begin
            if (last_step && (f_in_ready || !mask_ff[cur_ch])) begin
               nxt_st = S_END;
            end
         end
         S_END: begin
            if (f_in_ready) begin
               nxt_st = S_IDLE;  // [RULE2]
            end
         end
         default: begin
            nxt_st = S_IDLE;
         end
      endcase
   end

   wire buf_clr;
   assign buf_clr = i_data_reset | i_soft_reset;

   // Formatter state
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         st_ff <= S_IDLE;
         step_ff <= '0;
         gate_rdy_ff <= 1'b1;
      end else if (buf_clr) begin
         st_ff <= S_IDLE;
         step_ff <= '0;
         gate_rdy_ff <= 1'b1;
      end else begin
         st_ff <= nxt_st;
         gate_rdy_ff <= (nxt_st == S_IDLE);
         if (st_ff != S_DATA) begin
            step_ff <= '0;
         end else if (f_in_ready || !mask_ff[cur_ch]) begin
            step_ff <= step_ff + 5'h01;  // [RULE15]
         end
      end
   end

   // Sample capture
   always_ff @(posedge i_core_clk) begin
      if (st_ff == S_IDLE && i_gate_done) begin
         val_ff <= i_samp_value;
         ovf_ff <= i_samp_ovf;
         below_ff <= i_samp_below;
         mask_ff <= qual;
         cnt_ff <= qual_cnt;
         evc_ff <= i_event_count;
         crate_lat_ff <= crate_ff;
      end
   end

   // Staging FIFO, back-pressure
   wire        f_out_valid;
   wire [31:0] f_out_data;
   wire        mem_full;
   ebf_fifo #(
      .WIDTH (32),
      .DEPTH (FIFO_DEP)
   ) u_fifo (
      .i_core_clk  (i_core_clk),
      .i_reset     (i_reset),
      .i_flush     (buf_clr),
      .i_in_valid  (f_in_valid),
      .o_in_ready  (f_in_ready),
      .i_in_data   (fmt_word),
      .o_out_valid (f_out_valid),
      .i_out_ready (~mem_full),
      .o_out_data  (f_out_data)
   );

   // Access decode
   wire m_single;
   wire m_cblt;
   wire m_mcst;
   wire rd;
   wire wr;
   wire hit_buf;
   wire hit_rom;
   wire a_slot;
   wire a_set2;
   wire a_clr2;
   wire a_crate;
   wire no_src;
   wire slot_wr;
   wire wr_ok;
   wire rd_ok;
   assign m_single = (i_acc_mode == AM_SINGLE);
   assign m_cblt   = (i_acc_mode == AM_CBLT);
   assign m_mcst   = (i_acc_mode == AM_MCST);
   assign rd = i_acc_req & ~i_acc_write;
   assign wr = i_acc_req & i_acc_write;
   assign hit_buf = (m_single & (i_acc_addr <= `EBF_OFS_BUF_HI)) |
                    (m_cblt & (i_acc_addr <= `EBF_OFS_CBLT_HI));  // [RULE17]
   assign hit_rom = (i_acc_addr >= `EBF_OFS_ROM_LO);  // [RULE22]
   assign a_slot  = (i_acc_addr == `EBF_OFS_SLOT);
   assign a_set2  = (i_acc_addr == `EBF_OFS_SET2);
   assign a_clr2  = (i_acc_addr == `EBF_OFS_CLR2);
   assign a_crate = (i_acc_addr == `EBF_OFS_CRATE);
   assign no_src = ~aux_s2_ff;
   assign slot_wr = wr & m_single & a_slot & no_src;  // [RULE19]
   assign wr_ok = slot_wr |
      (wr & m_single & (a_set2 | a_clr2 | a_crate)) |
      (wr & m_mcst & (i_acc_addr >= `EBF_OFS_MCST_LO) &
       (i_acc_addr <= `EBF_OFS_MCST_HI));  // [RULE18]
   assign rd_ok = rd & (hit_buf | (m_single & (hit_rom | a_slot |
      a_set2 | a_crate | (i_acc_addr == `EBF_OFS_FWREV))));  // [RULE21]
   wire ctl_wr;
   assign ctl_wr = wr & (m_single | m_mcst);

   // Buffer read side
   wire [MAW-1:0] rd_ptr1;
   wire [31:0] rd0;
   wire [31:0] rd1;
   wire        avail0;
   wire        avail1;
   wire [1:0]  pop_n;
   wire [1:0]  end_pops;
   wire        mem_push;
   wire        end_in;
   wire [31:0] nv_word;
   assign nv_word = {5'h00, WT_NV, 24'h00_0000};  // [RULE13]
   assign rd_ptr1 = rd_ptr_ff + MAW'(1);
   assign rd0 = ev_mem_ff[rd_ptr_ff];  // [RULE25]
   assign rd1 = ev_mem_ff[rd_ptr1];
   assign avail0 = (words_ff != '0);
   assign avail1 = (words_ff > MW'(1));
   assign pop_n = !(rd & hit_buf) ? 2'd0 :
                  (i_acc_wide & avail1) ? 2'd2 :
                  avail0 ? 2'd1 : 2'd0;  // [RULE1]
   assign end_pops =
      2'((pop_n != 2'd0) && (rd0[`EBF_TYPE_LSB +: 3] == WT_END)) +
      2'((pop_n == 2'd2) && (rd1[`EBF_TYPE_LSB +: 3] == WT_END));
   assign mem_full = (words_ff == MW'(MEM_DEPTH));
   assign mem_push = f_out_valid & ~mem_full;
   assign end_in   = mem_push &
                     (f_out_data[`EBF_TYPE_LSB +: 3] == WT_END);

   // Read data selection
   logic [63:0] nxt_rdata;
   always_comb begin
      nxt_rdata = '0;
      if (hit_buf) begin
         nxt_rdata[31:0] = avail0 ? rd0 : nv_word;  // [RULE13]
         if (i_acc_wide) begin
            nxt_rdata[63:32] = avail1 ? rd1 : nv_word;
         end
      end else if (hit_rom) begin
         nxt_rdata = '0;  // [RULE22]
      end else if (a_slot) begin
         nxt_rdata[4:0] = slot_ff;
      end else if (a_set2) begin
         nxt_rdata[15:0] = set2_ff;
      end else if (a_crate) begin
         nxt_rdata[7:0] = crate_ff;
      end else begin
         nxt_rdata[15:0] = FW_REV;  // [RULE21]
      end
   end

   // Event memory write
   always_ff @(posedge i_core_clk) begin
      if (mem_push) begin
         ev_mem_ff[wr_ptr_ff] <= f_out_data;
      end
   end

   // Memory pointers
   wire [MAW:0] nxt_events;
   assign nxt_events = events_ff + MW'(end_in) - MW'(end_pops);
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         words_ff  <= '0;
         events_ff <= '0;
         evp_ff    <= 1'b0;
      end else if (buf_clr) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         words_ff  <= '0;
         events_ff <= '0;
         evp_ff    <= 1'b0;
      end else begin
         wr_ptr_ff <= wr_ptr_ff + MAW'(mem_push);
         rd_ptr_ff <= rd_ptr_ff + MAW'(pop_n);  // [RULE25]
         words_ff  <= words_ff + MW'(mem_push) - MW'(pop_n);
         events_ff <= nxt_events;
         evp_ff    <= (nxt_events != '0);  // [RULE24]
      end
   end

   // Bus answer registers
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         ack_ff   <= 1'b0;
         nack_ff  <= 1'b0;
         rdata_ff <= '0;
      end else begin
         ack_ff  <= rd_ok | wr_ok;
         nack_ff <= i_acc_req & ~(rd_ok | wr_ok);  // [RULE17]
         if (rd_ok) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   // Pin synchronisers
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         slot_s1_ff <= '0;
         slot_s2_ff <= '0;
         aux_s1_ff  <= 1'b0;
         aux_s2_ff  <= 1'b0;
      end else begin
         slot_s1_ff <= i_slot_pins;
         slot_s2_ff <= slot_s1_ff;
         aux_s1_ff  <= i_aux_present;
         aux_s2_ff  <= aux_s1_ff;
      end
   end

   // Control registers
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         slot_ff     <= `EBF_SLOT_RST;
         load_cnt_ff <= '0;
         crate_ff    <= `EBF_CRATE_RST;
         set2_ff     <= `EBF_SET2_RST;
      end else if (i_soft_reset) begin
         load_cnt_ff <= '0;  // [RULE23]
         crate_ff    <= `EBF_CRATE_RST;
         set2_ff     <= `EBF_SET2_RST;
      end else begin
         if (load_cnt_ff != 2'h3) begin
            load_cnt_ff <= load_cnt_ff + 2'h1;
         end
         if (load_cnt_ff == `EBF_SLOT_LOAD_AT && aux_s2_ff) begin
            slot_ff <= slot_s2_ff;  // [RULE23]
         end else if (slot_wr) begin
            slot_ff <= i_acc_wdata[4:0];  // [RULE20]
         end
         if (ctl_wr && a_crate) begin
            crate_ff <= i_acc_wdata[7:0];
         end
         if (ctl_wr && a_set2) begin
            set2_ff <= set2_ff | i_acc_wdata;
         end else if (ctl_wr && a_clr2) begin
            set2_ff <= set2_ff & ~i_acc_wdata;
         end
      end
   end

   // Outputs
   assign o_gate_ready     = gate_rdy_ff;
   assign o_acc_ack        = ack_ff;
   assign o_acc_nack       = nack_ff;
   assign o_acc_rdata      = rdata_ff;
   assign o_events_present = evp_ff;
   assign o_no_slot_source = ~aux_s2_ff;
endmodule : ebf_formatter_top

// ---- tb/ebf_props.sv ----
// Bus answer and gate-ready checks
module ebf_props #(
   parameter logic [15:0] FW_REV = 16'h0A5C // Arbitrary value
) (
   input wire logic        i_core_clk,      // Clock
   input wire logic        i_reset,         // Async reset
   input wire logic        i_acc_req,       // Strobe
   input wire logic        i_acc_write,     // Write
   input wire logic        i_acc_wide,      // Wide read
   input wire logic [1:0]  i_acc_mode,      // Mode
   input wire logic [15:0] i_acc_addr,      // Offset
   input wire logic        i_gate_done,     // Gate
   input wire logic        o_gate_ready,    // Idle
   input wire logic        o_acc_ack,       // Ack
   input wire logic        o_acc_nack,      // Nack
   input wire logic [63:0] o_acc_rdata,     // Read data
   input wire logic        o_no_slot_source // No slot pins
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_reset);
   // Single read
   wire rd0 = i_acc_req && !i_acc_write && i_acc_mode == 2'h0;
   // Answer next edge
   sequence s_ack;
      ##1 (o_acc_ack && !o_acc_nack);
   endsequence
   sequence s_nack;
      ##1 (o_acc_nack && !o_acc_ack);
   endsequence
   AST_ONE_ANSWER: assert property (i_acc_req |-> s_ack or s_nack)
      else $error("no answer");
   AST_QUIET: assert property (
      !i_acc_req |=> !o_acc_ack && !o_acc_nack)
      else $error("stray answer");
   AST_BUF_TYPE: assert property (
      rd0 && i_acc_addr <= 16'h07FC && !i_acc_wide |-> s_ack ##0
      (!o_acc_rdata[24] && o_acc_rdata[63:32] == 32'h0))
      else $error("bad word type");
   AST_CBLT: assert property (i_acc_req && i_acc_mode == 2'h1 &&
      (i_acc_write || i_acc_addr > 16'h07FF) |-> s_nack)
      else $error("chained access answered");
   AST_MCST: assert property (
      i_acc_req && i_acc_mode == 2'h2 && !i_acc_write |-> s_nack)
      else $error("multicast read answered");
   AST_FWREV: assert property (rd0 && i_acc_addr == 16'h1000
      |-> s_ack ##0 o_acc_rdata == {48'h0, FW_REV})
      else $error("bad revision");
   AST_ROM: assert property (
      rd0 && i_acc_addr[15] |-> s_ack ##0 o_acc_rdata == 64'h0)
      else $error("bad rom read");
   AST_SLOT: assert property (i_acc_req && i_acc_write &&
      i_acc_mode == 2'h0 && i_acc_addr == 16'h1002 && !o_no_slot_source
      |-> s_nack)
      else $error("slot write taken");
   AST_GATE: assert property (
      $fell(o_gate_ready) |-> $past(i_gate_done))
      else $error("busy without gate");
endmodule : ebf_props

bind ebf_formatter_top ebf_props #(.FW_REV(FW_REV)) u_props (
   .i_core_clk(i_core_clk), .i_reset(i_reset), .i_acc_req(i_acc_req),
   .i_acc_write(i_acc_write), .i_acc_wide(i_acc_wide),
   .i_acc_mode(i_acc_mode), .i_acc_addr(i_acc_addr),
   .i_gate_done(i_gate_done), .o_gate_ready(o_gate_ready),
   .o_acc_ack(o_acc_ack), .o_acc_nack(o_acc_nack),
   .o_acc_rdata(o_acc_rdata), .o_no_slot_source(o_no_slot_source));

// ---- tb/ebf_bus_master.sv ----
// Bus master model
module ebf_bus_master (
   input  wire logic   i_core_clk, // Clock
   input  wire logic   i_ack,      // Access done
   output logic        o_req,      // Strobe
   output logic        o_write,    // Write flag
   output logic        o_wide,     // Wide read
   output logic [1:0]  o_mode,     // Access mode
   output logic [15:0] o_addr,     // Byte offset
   output logic [15:0] o_wdata     // Write data
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle bus at time zero
   initial begin
      {o_req, o_write, o_wide, o_mode, o_addr, o_wdata} = '0;
   end
   // One strobe, answer taken next edge
   task automatic access(input logic [1:0] m, input logic w, wd,
                         input logic [15:0] a, d, output logic ok);
      @(posedge i_core_clk);
      #1;
      {o_req, o_write, o_wide} = {1'b1, w, wd};
      {o_mode, o_addr, o_wdata} = {m, a, d};
      @(posedge i_core_clk);
      #1;
      ok = i_ack;
      o_req = 1'b0;
      o_addr = ~o_addr;   // Released lines lose old value
      o_wdata = ~o_wdata;
   endtask : access
endmodule : ebf_bus_master

// ---- tb/ebf_formatter_top_bench.sv ----
// Self-checking formatter bench
module ebf_formatter_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int N = 32;             // Channels
   localparam logic [4:0] GEO = 5'h0B; // Slot pins
   logic clk, rst, gd, aux, rdy, evp, nss, req, wr, wd, ack, nack;
   logic [1:0]    mode;    // Access mode
   logic [15:0]   addr, wdata;
   logic [63:0]   rdata;   // Read data
   logic [N*12-1:0] val;   // Samples
   logic [N-1:0]  kill;    // Disabled channels
   logic [23:0]   cnt;     // Event counter
   int            err_total, num_checks;
   ebf_formatter_top #(.NCH(N), .FW_REV(16'h1234)) dut (
      .i_core_clk(clk), .i_reset(rst), .i_data_reset(1'b0),
      .i_soft_reset(1'b0), .i_slot_pins(GEO), .i_aux_present(aux),
      .i_gate_done(gd), .i_samp_value(val), .i_samp_ovf(N'(1) << 17),
      .i_samp_below(N'(1) << 3), .i_chan_kill(kill),
      .i_zero_supp_en(1'b1), .i_ovf_supp_en(1'b0), .i_event_count(cnt),
      .o_gate_ready(rdy), .i_acc_req(req), .i_acc_write(wr),
      .i_acc_wide(wd), .i_acc_mode(mode), .i_acc_addr(addr),
      .i_acc_wdata(wdata), .o_acc_ack(ack), .o_acc_nack(nack),
      .o_acc_rdata(rdata), .o_events_present(evp),
      .o_no_slot_source(nss));
   ebf_bus_master u_mst (.i_core_clk(clk), .i_ack(ack), .o_req(req),
      .o_write(wr), .o_wide(wd), .o_mode(mode), .o_addr(addr),
      .o_wdata(wdata));
   // Compare and count
   task automatic chk(input string nm, input logic [63:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One gate, wait for idle
   task automatic fire(input logic [N-1:0] k);
      int n;
      @(posedge clk);
      #1;
      kill = k;
      cnt = cnt + 24'h1;
      gd = 1'b1;
      @(posedge clk);
      #1;
      gd = 1'b0;
      for (n = 0; n < 200 && rdy !== 1'b1; n++) @(posedge clk);
      chk("ready", rdy, 1'b1);
      repeat (4) @(posedge clk);
      #1;
   endtask : fire
   // Register reads and refusals
   task automatic t_regs;
      logic ok;
      logic [18:0] bad [6] = '{19'h0_0800, 19'h2_103C, 19'h5_0000,
                               19'h1_0800, 19'h4_1002, 19'h3_0000};
      u_mst.access(2'h0, 1'b0, 1'b0, 16'h0000, 16'h0, ok);
      chk("empty", rdata, 64'h0000_0000_0600_0000);
      u_mst.access(2'h0, 1'b0, 1'b0, 16'h1000, 16'h0, ok);
      chk("fwrev", rdata, 64'h0000_0000_0000_1234);
      u_mst.access(2'h0, 1'b0, 1'b0, 16'hC000, 16'h0, ok);
      chk("rom", {ok, rdata[62:0]}, 64'h8000_0000_0000_0000);
      foreach (bad[i]) begin
         u_mst.access(bad[i][17:16], bad[i][18], 1'b0, bad[i][15:0],
                      16'h0, ok);
         chk("refused", ok, 1'b0);
      end
      $display("t_regs done");
   endtask : t_regs
   // One event, channel 3 dropped or kept
   task automatic t_event(input logic keep);
      logic        ok;
      logic [31:0] q[$], e, e2;
      u_mst.access(2'h2, 1'b1, 1'b0, 16'h103C, 16'h005A, ok);
      chk("mcst crate", ok, 1'b1);
      u_mst.access(2'h0, 1'b1, 1'b0, keep ? 16'h1032 : 16'h1034,
                   16'h0018, ok);
      fire(~((N'(1) << 2) | (N'(1) << 3) | (N'(1) << 17)));
      chk("present", evp, 1'b1);
      q = '{{GEO, 3'h2, 8'h5A, 2'h0, keep ? 6'h3 : 6'h2, 8'h0},
            {GEO, 6'h0, 5'd17, 4'h1, 12'h111},
            {GEO, 6'h0, 5'd2, 4'h0, 12'h102}};
      if (keep) q.push_back({GEO, 6'h0, 5'd3, 4'h2, 12'h103});
      q.push_back({GEO, 3'h4, cnt});
      while (q.size() > 0) begin
         e = q.pop_front();
         e2 = q.size() > 0 ? q.pop_front() : 32'h0600_0000;
         u_mst.access({1'b0, keep}, 1'b0, 1'b1, 16'h07F8, 16'h0, ok);
         chk("pair", rdata, {e2, e});
         chk("pair ack", ok, 1'b1);
      end
      chk("drained", evp, 1'b0);
      $display("t_event done");
   endtask : t_event
   // No channel stored
   task automatic t_none;
      logic ok;
      fire('1);
      chk("none present", evp, 1'b0);
      u_mst.access(2'h0, 1'b0, 1'b0, 16'h0004, 16'h0, ok);
      chk("none read", rdata, 64'h0000_0000_0600_0000);
      $display("t_none done");
   endtask : t_none
   // Slot writable without slot pins
   task automatic t_slot;
      logic ok;
      aux = 1'b0;
      repeat (5) @(posedge clk);
      chk("no source", nss, 1'b1);
      u_mst.access(2'h0, 1'b1, 1'b0, 16'h1002, 16'h0007, ok);
      chk("slot wr", ok, 1'b1);
      u_mst.access(2'h0, 1'b0, 1'b0, 16'h1002, 16'h0, ok);
      chk("slot rd", rdata, 64'h0000_0000_0000_0007);
      $display("t_slot done");
   endtask : t_slot
   // Verdict
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   // Clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Scenarios
   initial begin
      {rst, gd, aux, kill, cnt} = {1'b1, 1'b0, 1'b1, {N{1'b1}}, 24'h00_ABC0};
      for (int c = 0; c < N; c++) val[c*12+:12] = 12'h100 + 12'(c);
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (4) @(posedge clk);
      t_regs;
      t_event(1'b0);
      t_event(1'b1);
      t_none;
      t_slot;
      print_verdict;
   end
   // Watchdog
   initial begin
      #200us;
      err_total++;
      print_verdict;
   end
endmodule : ebf_formatter_top_bench
